// [cpsc_pkg.sv]
// Shared constants, types and helpers of the colour and proximity sensor core.
package cpsc_pkg;
  // Clock and timing.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned LED_PERIOD_NS = 14000;
  localparam int unsigned LED_PERIOD_CYC = LED_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned LED_HIGH_CYC = LED_PERIOD_CYC / 2;
  localparam logic [8:0] LED_LAST = 9'(LED_PERIOD_CYC - 1);
  localparam logic [8:0] LED_HIGH = 9'(LED_HIGH_CYC);
  localparam int unsigned SCL_MIN_PERIOD_NS = 2500;
  localparam int unsigned SCL_MIN_CYC =
    (SCL_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] SCL_MIN = 7'(SCL_MIN_CYC);

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ATIME = 8'h04;
  localparam logic [7:0] OFS_WTIME = 8'h08;
  localparam logic [7:0] OFS_LED = 8'h0C;
  localparam logic [7:0] OFS_PERS = 8'h10;
  localparam logic [7:0] OFS_CTHR = 8'h14;
  localparam logic [7:0] OFS_PTHR = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam logic [7:0] OFS_ICLR = 8'h20;
  localparam logic [7:0] OFS_IEN = 8'h24;
  localparam logic [7:0] OFS_DAT0 = 8'h28;
  localparam logic [7:0] OFS_DAT1 = 8'h2C;
  localparam logic [7:0] OFS_PDAT = 8'h30;

  // Field positions.
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned CTRL_PON = 0;
  localparam int unsigned CTRL_CEN = 1;
  localparam int unsigned CTRL_PEN = 2;
  localparam int unsigned CTRL_WEN = 3;
  localparam int unsigned ST_W = 5;
  localparam int unsigned ST_CINT = 0;
  localparam int unsigned ST_PINT = 1;
  localparam int unsigned ST_CDONE = 2;
  localparam int unsigned ST_PDONE = 3;
  localparam int unsigned ST_LINK = 4;

  // Values after reset.
  localparam logic [15:0] RST_ATIME = 16'h0100;
  localparam logic [15:0] RST_WTIME = 16'h0100;
  localparam logic [7:0] RST_PULSES = 8'h01;
  localparam logic [1:0] RST_LEDCUR = 2'h0;
  localparam logic [31:0] RST_THR = 32'hFFFF_0000;

  typedef enum logic [1:0] {S_IDLE, S_COLOUR, S_PROX, S_WAIT} cpsc_state_t;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } cpsc_limits_t;

  typedef struct packed {
    logic [15:0] blue;
    logic [15:0] green;
    logic [15:0] red;
    logic [15:0] clear;
  } cpsc_colour_t;

  function automatic logic out_of_range(logic [15:0] v, cpsc_limits_t lim);
    return (v > lim.hi) || (v < lim.lo);
  endfunction : out_of_range

  // A zero persistence behaves as one, so every event fires.
  function automatic logic pers_met(logic [3:0] cnt, logic [3:0] pers);
    return ({1'b0, cnt} + 5'h01) >= {1'b0, (pers == 4'h0) ? 4'h1 : pers};
  endfunction : pers_met

  function automatic logic tick_done(logic [15:0] t, logic [15:0] lim);
    return ({1'b0, t} + 17'h00001) >= {1'b0, lim};
  endfunction : tick_done
endpackage : cpsc_pkg

// [cpsc_integ.sv]
// Saturating integrating counter for one converter channel.
`timescale 1ns/10ps
module cpsc_integ #(
  parameter int unsigned W = 16,
  parameter int unsigned N = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [N-1:0] hit_i,
  output logic [W-1:0] acc_o
);
  logic [W-1:0] acc_ff;
  logic [W:0] inc;
  logic [W:0] sum;

  // Diodes of one filter type add their charge pulses together.
  always_comb begin
    inc = '0;
    for (int i = 0; i < N; i++) begin
      inc = inc + (W+1)'(hit_i[i]);
    end
    sum = {1'b0, acc_ff} + inc;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || clr_i) begin
      acc_ff <= '0;
    end else if (en_i) begin
      acc_ff <= sum[W] ? '1 : sum[W-1:0];
    end
  end

  assign acc_o = acc_ff;
endmodule : cpsc_integ

// [cpsc_core.sv]
// Sensor core: sequencer, converters, thresholds, LED driver and AHB slave.
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Overview of operation
// R1 - Four colour converters integrate simultaneously, 16 bits.
// R2 - Finished conversions load the result registers.
// R3 - Results double buffered; reads never mix.
// R4 - Enabled threshold interrupt holds until host clears.
// R5 - Event when result above upper or below lower.
// R6 - Interrupt after programmed consecutive events.
// R7 - Colour and proximity thresholds kept separately.
// R8 - LED sink current selects 12.5/25/50/100 mA.
// R9 - One to 255 LED pulses per proximity.
// R10 - Each LED pulse repeats every 14 us.
// R11 - Host link clock at most 400 kHz.
// R12 - Sequencer may wait in low power between.
// R13 - Four diodes per filter type combine per channel.
// R14 - Interrupt pin open drain, pulled low pending.
// R15 - LED sink driven only during proximity pulses.
// R16 - In-range conversion clears its persistence counter.
module cpsc_core (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [15:0] pd_pulse_i,
  input wire logic prox_pulse_i,
  input wire logic scl_i,
  output logic ir_led_sink_o,
  output logic ir_led_sink_oe_o,
  output logic [1:0] led_current_o,
  output logic int_n_o,
  output logic int_n_oe_o,
  output logic low_power_o
);
  import cpsc_pkg::*;

  logic [15:0] pd_s1_ff, pd_s2_ff;
  logic prox_s1_ff, prox_s2_ff;
  logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [15:0] atime_ff, wtime_ff;
  logic [7:0] pulses_ff, pulses_eff;
  logic [1:0] led_cur_ff;
  logic [3:0] cpers_ff, ppers_ff, ccnt_ff, pcnt_ff;
  cpsc_limits_t cthr_ff, pthr_ff;
  logic [ST_W-1:0] stat_ff, ien_ff, stat_set, stat_clr;
  cpsc_state_t state_ff, nxt_state;
  logic [15:0] timer_ff;
  logic [8:0] led_cyc_ff;
  logic [7:0] pulse_cnt_ff;
  logic led_on_ff, irq_ff, low_power_ff;
  logic col_last, prox_last, col_cap_ff, prox_cap_ff;
  cpsc_colour_t col_acc, col_data_ff;
  logic [15:0] prox_acc, prox_data_ff;
  logic [31:0] dat1_snap_ff, hrdata_ff, rd_val;
  logic col_evt, prox_evt, col_fire, prox_fire, scl_fast;
  logic [6:0] scl_gap_ff;
  logic ap_take, ap_rd, dp_we_ff;
  logic [7:0] dp_addr_ff;

  // Pins from the analog side and the link pass two flip-flops first.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pd_s1_ff <= 16'h0000;
      pd_s2_ff <= 16'h0000;
      prox_s1_ff <= 1'b0;
      prox_s2_ff <= 1'b0;
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_s3_ff <= 1'b1;
    end else begin
      pd_s1_ff <= pd_pulse_i;
      pd_s2_ff <= pd_s1_ff;
      prox_s1_ff <= prox_pulse_i;
      prox_s2_ff <= prox_s1_ff;
      scl_s1_ff <= scl_i;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
    end
  end

  // R11 link speed check
  // The gap saturates, so a link that stood still never looks too fast.
  assign scl_fast = scl_s2_ff && !scl_s3_ff && (scl_gap_ff < SCL_MIN);
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || (scl_s2_ff && !scl_s3_ff)) begin
      scl_gap_ff <= (!rst_n_i) ? SCL_MIN : 7'h01;
    end else if (scl_gap_ff < SCL_MIN) begin
      scl_gap_ff <= scl_gap_ff + 7'h01;
    end
  end

  // AHB-Lite slave with zero wait states and an always OKAY answer.
  assign ap_take = hsel_i && htrans_i[1] && hready_i;
  assign ap_rd = ap_take && !hwrite_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_ff;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dp_we_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
    end else begin
      dp_we_ff <= ap_take && hwrite_i;
      dp_addr_ff <= haddr_i[7:0];
    end
  end

  always_comb begin
    case (haddr_i[7:0])
      OFS_CTRL: rd_val = {{(32-CTRL_W){1'b0}}, ctrl_ff};
      OFS_ATIME: rd_val = {16'h0000, atime_ff};
      OFS_WTIME: rd_val = {16'h0000, wtime_ff};
      OFS_LED: rd_val = {16'h0000, pulses_ff, 6'h00, led_cur_ff};
      OFS_PERS: rd_val = {24'h000000, ppers_ff, cpers_ff};
      OFS_CTHR: rd_val = cthr_ff;
      OFS_PTHR: rd_val = pthr_ff;
      OFS_STAT: rd_val = {{(32-ST_W){1'b0}}, stat_ff};
      OFS_IEN: rd_val = {{(32-ST_W){1'b0}}, ien_ff};
      OFS_DAT0: rd_val = {col_data_ff.red, col_data_ff.clear};
      OFS_DAT1: rd_val = dat1_snap_ff;
      OFS_PDAT: rd_val = {16'h0000, prox_data_ff};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // R3 paired read snapshot
  // Reading the low colour word freezes the high word for the next read.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      hrdata_ff <= 32'h0000_0000;
      dat1_snap_ff <= 32'h0000_0000;
    end else begin
      if (ap_rd) begin
        hrdata_ff <= rd_val;
      end
      if (ap_rd && haddr_i[7:0] == OFS_DAT0) begin
        dat1_snap_ff <= {col_data_ff.blue, col_data_ff.green};
      end
    end
  end

  // Configuration registers written in the data phase.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= '0;
      atime_ff <= RST_ATIME;
      wtime_ff <= RST_WTIME;
      pulses_ff <= RST_PULSES;
      led_cur_ff <= RST_LEDCUR;
      cpers_ff <= 4'h0;
      ppers_ff <= 4'h0;
      cthr_ff <= RST_THR;
      pthr_ff <= RST_THR;
      ien_ff <= '0;
    end else if (dp_we_ff) begin
      case (dp_addr_ff)
        OFS_CTRL: ctrl_ff <= hwdata_i[CTRL_W-1:0];
        OFS_ATIME: atime_ff <= hwdata_i[15:0];
        OFS_WTIME: wtime_ff <= hwdata_i[15:0];
        OFS_LED: begin
          pulses_ff <= hwdata_i[15:8];
          led_cur_ff <= hwdata_i[1:0];
        end
        OFS_PERS: begin
          cpers_ff <= hwdata_i[3:0];
          ppers_ff <= hwdata_i[7:4];
        end
        OFS_CTHR: cthr_ff <= hwdata_i;
        OFS_PTHR: pthr_ff <= hwdata_i;
        OFS_IEN: ien_ff <= hwdata_i[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // R8 LED current select
  assign led_current_o = led_cur_ff;
  // R9 pulse count range
  assign pulses_eff = (pulses_ff == 8'h00) ? 8'h01 : pulses_ff;

  // R12 measurement sequencer
  always_comb begin
    nxt_state = state_ff;
    col_last = 1'b0;
    prox_last = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (ctrl_ff[CTRL_CEN]) begin
          nxt_state = S_COLOUR;
        end else if (ctrl_ff[CTRL_PEN]) begin
          nxt_state = S_PROX;
        end else if (ctrl_ff[CTRL_WEN]) begin
          nxt_state = S_WAIT;
        end
      end
      S_COLOUR: begin
        if (tick_done(timer_ff, atime_ff)) begin
          col_last = 1'b1;
          nxt_state = ctrl_ff[CTRL_PEN] ? S_PROX :
                      ctrl_ff[CTRL_WEN] ? S_WAIT : S_IDLE;
        end
      end
      S_PROX: begin
        if (led_cyc_ff == LED_LAST && pulse_cnt_ff + 8'h01 >= pulses_eff) begin
          prox_last = 1'b1;
          nxt_state = ctrl_ff[CTRL_WEN] ? S_WAIT : S_IDLE;
        end
      end
      S_WAIT: begin
        if (tick_done(timer_ff, wtime_ff)) begin
          nxt_state = S_IDLE;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
    if (!ctrl_ff[CTRL_PON]) begin
      nxt_state = S_IDLE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= S_IDLE;
      timer_ff <= 16'h0000;
      low_power_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= (nxt_state != state_ff) ? 16'h0000 : timer_ff + 16'h0001;
      low_power_ff <= (nxt_state == S_WAIT);
    end
  end
  assign low_power_o = low_power_ff;

  // R10 pulse period timing
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || state_ff != S_PROX) begin
      led_cyc_ff <= 9'h000;
      pulse_cnt_ff <= 8'h00;
      led_on_ff <= 1'b0;
    end else begin
      led_cyc_ff <= (led_cyc_ff == LED_LAST) ? 9'h000 : led_cyc_ff + 9'h001;
      if (led_cyc_ff == LED_LAST) begin
        pulse_cnt_ff <= pulse_cnt_ff + 8'h01;
      end
      led_on_ff <= (led_cyc_ff < LED_HIGH) && !prox_last;
    end
  end

  // R15 open drain LED sink
  assign ir_led_sink_o = 1'b0;
  assign ir_led_sink_oe_o = led_on_ff;

  // R1 parallel colour converters
  // R13 diode groups combined
  // Result slots start with clear while pin groups start with red.
  for (genvar ch = 0; ch < 4; ch++) begin : g_colour
    cpsc_integ #(.W(16), .N(4)) u_integ (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .clr_i(state_ff != S_COLOUR && nxt_state == S_COLOUR),
      .en_i(state_ff == S_COLOUR),
      .hit_i(pd_s2_ff[4*((ch+3)%4) +: 4]),
      .acc_o(col_acc[16*ch +: 16])
    );
  end

  // Only charge seen while the LED is lit counts as reflected light.
  cpsc_integ #(.W(16), .N(1)) u_prox (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(state_ff != S_PROX && nxt_state == S_PROX),
    .en_i(state_ff == S_PROX),
    .hit_i(prox_s2_ff && led_on_ff),
    .acc_o(prox_acc)
  );

  // R2 result register load
  // Capture one cycle late so the final increment is included.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      col_cap_ff <= 1'b0;
      prox_cap_ff <= 1'b0;
      col_data_ff <= '0;
      prox_data_ff <= 16'h0000;
    end else begin
      col_cap_ff <= col_last;
      prox_cap_ff <= prox_last;
      if (col_cap_ff) begin
        col_data_ff <= col_acc;
      end
      if (prox_cap_ff) begin
        prox_data_ff <= prox_acc;
      end
    end
  end

  // R5 threshold window test
  // R7 separate limit sets
  assign col_evt = out_of_range(col_acc.clear, cthr_ff);
  assign prox_evt = out_of_range(prox_acc, pthr_ff);
  // R6 persistence gate
  assign col_fire = col_cap_ff && col_evt && pers_met(ccnt_ff, cpers_ff);
  assign prox_fire = prox_cap_ff && prox_evt && pers_met(pcnt_ff, ppers_ff);

  // R16 persistence counter reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ccnt_ff <= 4'h0;
      pcnt_ff <= 4'h0;
    end else begin
      if (col_cap_ff) begin
        ccnt_ff <= (!col_evt || col_fire) ? 4'h0 : ccnt_ff + 4'h1;
      end
      if (prox_cap_ff) begin
        pcnt_ff <= (!prox_evt || prox_fire) ? 4'h0 : pcnt_ff + 4'h1;
      end
    end
  end

  // R4 sticky status bits
  // A new event in the clearing cycle wins, so no event is lost.
  assign stat_set = {scl_fast, prox_cap_ff, col_cap_ff, prox_fire, col_fire};
  assign stat_clr = (dp_we_ff && dp_addr_ff == OFS_ICLR) ?
                    hwdata_i[ST_W-1:0] : '0;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      stat_ff <= (stat_ff & ~stat_clr) | stat_set;
      irq_ff <= |(stat_ff & ien_ff);
    end
  end

  // R14 open drain interrupt
  assign int_n_o = 1'b0;
  assign int_n_oe_o = irq_ff;

  // Checks and coverage.
  logic led_prev_ff;
  logic [8:0] led_gap_ff;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      led_prev_ff <= 1'b0;
      led_gap_ff <= 9'h000;
    end else begin
      led_prev_ff <= led_on_ff;
      led_gap_ff <= (led_on_ff && !led_prev_ff) ? 9'h000 : led_gap_ff + 9'h001;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_int_pin_level: assert property ( // R14
    |(stat_ff & ien_ff) |=> int_n_oe_o && !int_n_o)
    else $error("Interrupt pin not pulled while enabled status set.");
  a_int_sticky: assert property ( // R4
    stat_ff[ST_CINT] && stat_clr == '0 |=> stat_ff[ST_CINT] ##1 int_n_oe_o
      || !$past(ien_ff[ST_CINT]))
    else $error("Colour interrupt dropped without a clear.");
  a_led_only_prox: assert property ( // R15
    ir_led_sink_oe_o |-> $past(state_ff) == S_PROX)
    else $error("LED sink driven outside proximity pulses.");
  a_led_period: assert property ( // R10
    led_on_ff && !led_prev_ff && pulse_cnt_ff != 8'h00 |->
      led_gap_ff == LED_LAST)
    else $error("LED pulse period wrong.");
  a_pulse_limit: assert property ( // R9
    state_ff == S_PROX |-> pulse_cnt_ff < pulses_eff)
    else $error("More LED pulses than programmed.");
  a_result_load: assert property ( // R2
    col_cap_ff |=> col_data_ff == $past(col_acc))
    else $error("Colour results not loaded at conversion end.");
  a_snap_pair: assert property ( // R3
    ap_rd && haddr_i[7:0] == OFS_DAT0 |=>
      dat1_snap_ff == $past({col_data_ff.blue, col_data_ff.green}))
    else $error("High colour word not frozen with the low word.");
  a_thr_fire: assert property ( // R5
    col_fire |-> col_evt ##1 stat_ff[ST_CINT])
    else $error("Colour threshold event not flagged.");
  a_pers_reset: assert property ( // R16
    prox_cap_ff && !prox_evt |=> pcnt_ff == 4'h0 && !stat_set[ST_PINT])
    else $error("Proximity persistence not cleared in range.");
  a_wait_gate: assert property ( // R12
    state_ff != S_WAIT ##1 state_ff == S_WAIT |-> $past(ctrl_ff[CTRL_WEN]))
    else $error("Wait state entered while disabled.");

  c_colour_done: cover property (col_cap_ff ##1 stat_ff[ST_CDONE]);
  c_prox_int: cover property (prox_fire ##2 int_n_oe_o);
  c_wait_entry: cover property (state_ff == S_PROX ##1 state_ff == S_WAIT);
  c_link_fast: cover property (scl_fast);
endmodule : cpsc_core

// [cpsc_front_model.sv]
// Behavioural light front end and host link clock source for the core.
`timescale 1ns/10ps
module cpsc_front_model (
  input wire logic [15:0] pd_pat_i,
  input wire logic led_lit_i,
  input wire logic frame_i,
  input wire logic [15:0] half_ns_i,
  output logic [15:0] pd_pulse_o,
  output logic prox_pulse_o,
  output logic scl_o
);
  assign pd_pulse_o = pd_pat_i;
  // Reflected light only returns while the emitter is lit.
  assign prox_pulse_o = led_lit_i;
  // link clock rate
  // The bench sets the rate, so a frame that is too fast can be sent.
  // Outside frames the clock rests high, as the pull-up leaves it.
  initial scl_o = 1'b1;
  always begin
    wait (frame_i || !scl_o);
    #(half_ns_i) scl_o = ~scl_o;
  end
endmodule : cpsc_front_model

// [testbench.sv]
// Self-checking bench of the colour and proximity sensor core.
`timescale 1ns/10ps
module testbench;
  import cpsc_pkg::*;
  logic core_clk_i, rst_n_i, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, lfsr;
  logic [1:0] htrans, led_current, cur_exp;
  logic [15:0] pd_pulse, pd_pat, half_ns;
  logic prox_pulse, scl, frame, sink, sink_oe, int_n, int_n_oe, low_power;
  logic prox_win;
  int errors, n_compared, rises, hi_len, per_len, cnt, c, r, g, b, pc, ip;
  int ev_q[$];
  int np[4] = '{1, 3, 2, 255};
  logic [7:0] ra[12] = '{OFS_CTRL, OFS_ATIME, OFS_WTIME, OFS_LED, OFS_PERS,
    OFS_CTHR, OFS_PTHR, OFS_STAT, OFS_ICLR, OFS_IEN, OFS_DAT0, OFS_PDAT};
  logic [31:0] rv[12] = '{0, 32'h100, 32'h100, 32'h100, 0, RST_THR, RST_THR,
    0, 0, 0, 0, 0};

  cpsc_core dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .pd_pulse_i(pd_pulse),
    .prox_pulse_i(prox_pulse), .scl_i(scl), .ir_led_sink_o(sink),
    .ir_led_sink_oe_o(sink_oe), .led_current_o(led_current),
    .int_n_o(int_n), .int_n_oe_o(int_n_oe), .low_power_o(low_power));

  cpsc_front_model front (.pd_pat_i(pd_pat), .led_lit_i(sink_oe),
    .frame_i(frame), .half_ns_i(half_ns), .pd_pulse_o(pd_pulse),
    .prox_pulse_o(prox_pulse), .scl_o(scl));

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // One single transfer; the master holds each phase until hready is seen.
  task automatic ahb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge core_clk_i);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge core_clk_i);
    while (hreadyout !== 1'b1) @(posedge core_clk_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk_i);
    while (hreadyout !== 1'b1) @(posedge core_clk_i);
    rd = hrdata;
    check("response", {31'h0, hresp}, 32'h0);
  endtask : ahb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
    input string nm);
    ahb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask : rdc

  task automatic wait_stat(input int bit_no);
    cnt = 0;
    ahb(1'b0, OFS_STAT, 32'h0);
    while (rd[bit_no] !== 1'b1 && cnt < 30000) begin
      ahb(1'b0, OFS_STAT, 32'h0);
      cnt++;
    end
    check("status wait", {31'h0, rd[bit_no]}, 32'h1);
  endtask : wait_stat

  task automatic set_lim(input int mode);
    if (mode == 1)
      ahb(1'b1, OFS_CTHR, {16'(c - 1), 16'h0000});
    else if (mode == 2)
      ahb(1'b1, OFS_CTHR, {16'hFFFF, 16'(c + 1)});
    else
      ahb(1'b1, OFS_CTHR, RST_THR);
  endtask : set_lim

  // Watches the emitter pulse train and the open-drain pins every cycle.
  always @(posedge core_clk_i) begin
    per_len++;
    check("open drain values", {int_n, sink}, 2'b00);
    if (sink_oe === 1'b1) begin
      if (hi_len == 0 && rises > 0)
        check("led period", per_len, LED_PERIOD_CYC);
      if (hi_len == 0) begin
        rises++;
        per_len = 0;
      end
      hi_len++;
      check("sink window", prox_win, 1'b1);
      check("led current", led_current, cur_exp);
    end else begin
      if (hi_len > 0)
        check("led high time", hi_len, LED_HIGH_CYC);
      hi_len = 0;
    end
  end

  initial begin
    repeat (99000) @(posedge core_clk_i);
    errors++;
    $display("wrong value watchdog expected finish seen hang");
    give_verdict();
  end

  initial begin
    {rst_n_i, hsel, hwrite, htrans, haddr, hwdata, frame, prox_win} = '0;
    {pd_pat, cur_exp, errors, n_compared, rises, hi_len, per_len} = '0;
    half_ns = 16'd200;
    lfsr = 32'hCABB44AE;
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    check("reset pins", {low_power, int_n_oe, sink_oe}, 3'b000);
    foreach (ra[i]) rdc(ra[i], rv[i], "reset value");
    ahb(1'b1, 8'h34, 32'hFFFFFFFF);
    rdc(8'h34, 32'h0, "unmapped");
    ahb(1'b1, OFS_STAT, 32'h1F);
    rdc(OFS_STAT, 32'h0, "status read only");
    $display("test registers done");
    lfsr = lfsr_next(lfsr);
    pd_pat <= lfsr[15:0] | 16'h1000;
    r = 100 * $countones(lfsr[3:0]);
    g = 100 * $countones(lfsr[7:4]);
    b = 100 * $countones(lfsr[11:8]);
    c = 100 * $countones(lfsr[15:12] | 4'h1);
    ahb(1'b1, OFS_ATIME, 32'd100);
    ahb(1'b1, OFS_PERS, 32'hF2);
    ahb(1'b1, OFS_IEN, 32'h1);
    ev_q = '{1, 0, 2, 1, 2, 0, 1, 1};
    {pc, ip} = '0;
    set_lim(ev_q[0]);
    ahb(1'b1, OFS_CTRL, 32'h3);
    foreach (ev_q[k]) begin
      wait_stat(ST_CDONE);
      ahb(1'b1, OFS_ICLR, 32'h1 << ST_CDONE);
      if (k + 1 < ev_q.size()) set_lim(ev_q[k + 1]);
      pc = (ev_q[k] != 0) ? pc + 1 : 0;
      if (pc == 2) begin
        ip = 1;
        pc = 0;
      end
      ahb(1'b0, OFS_STAT, 32'h0);
      check("colour int", rd[ST_CINT], ip);
      check("prox int", rd[ST_PINT], 1'b0);
      check("int pin", int_n_oe, ip);
      if (k == 0) begin
        rdc(OFS_DAT0, {16'(r), 16'(c)}, "red clear");
        rdc(OFS_DAT1, {16'(b), 16'(g)}, "blue green");
      end
    end
    ahb(1'b1, OFS_CTRL, 32'h0);
    ahb(1'b1, OFS_IEN, 32'h0);
    ahb(1'b0, OFS_STAT, 32'h0);
    check("masked status", rd[ST_CINT], 1'b1);
    check("masked pin", int_n_oe, 1'b0);
    ahb(1'b1, OFS_IEN, 32'h1);
    ahb(1'b0, OFS_STAT, 32'h0);
    check("unmasked pin", int_n_oe, 1'b1);
    ahb(1'b1, OFS_ICLR, 32'h1);
    ahb(1'b0, OFS_STAT, 32'h0);
    check("cleared status", rd[ST_CINT], 1'b0);
    check("cleared pin", int_n_oe, 1'b0);
    $display("test colour done");
    ahb(1'b1, OFS_WTIME, 32'd2000);
    for (int i = 0; i < 4; i++) begin
      cur_exp = 2'(i);
      prox_win = 1'b1;
      rises = 0;
      ahb(1'b1, OFS_LED, (np[i] << 8) | i);
      ahb(1'b1, OFS_CTRL, 32'hD);
      wait_stat(ST_PDONE);
      check("wait state", low_power, 1'b1);
      // The input synchroniser loses two cycles of each reflected pulse.
      rdc(OFS_PDAT, np[i] * (LED_HIGH_CYC - 2), "prox data");
      ahb(1'b1, OFS_CTRL, 32'h0);
      ahb(1'b1, OFS_ICLR, 32'h1 << ST_PDONE);
      check("pulse count", rises, np[i]);
      check("awake", low_power, 1'b0);
      prox_win = 1'b0;
    end
    $display("test proximity done");
    frame <= 1'b1;
    half_ns <= 16'd1500;
    repeat (200) @(posedge core_clk_i);
    frame <= 1'b0;
    rdc(OFS_STAT, 32'h0, "slow link");
    frame <= 1'b1;
    half_ns <= 16'd200;
    repeat (100) @(posedge core_clk_i);
    frame <= 1'b0;
    rdc(OFS_STAT, 32'h1 << ST_LINK, "fast link");
    $display("test link done");
    give_verdict();
  end
endmodule : testbench
